/* src/uhrpc_port.sv */
// Root-hub port status and control logic behind an Avalon-MM register slave.
// What this block does
// - Owner bit clears when configure flag rises, and is forced to one while flag is zero.
// - Power bit shows switch state; without power no attach or detach is reported.
// - Over-current on a powered port with power control capability clears port power.
// - Line state shows D+ in bit 11 and D- in bit 10 whenever the port is powered.
// - Writing reset one starts bus reset; writing zero ends it after sufficient hold.
// - Reset reads one until done; a high-speed device gets enable set afterwards.
// - Reset ends and port settles within two milliseconds of software clearing reset.
// - Software uses reset only when not halted; while halted reset may be held.
// - Enable and suspend bits decode to disabled, enabled or suspended port state.
// - Suspend blocks traffic from the request on; bit reads one once the current transaction ends.
// - Zero writes to suspend ignored; cleared by resume falling or reset rising.
// - J-to-K while suspended sets force resume and change detect; software resume does not.
// - Resume K driven only while software holds force resume at one; bit holds until high-speed idle.
// - Over-current change sets on each over-current active change while power stays on; write one clears; zero unpowered.
// - Over-current active follows the over-current condition, read only.
// - Enable change sets only on error disable at EOF2; write one clears; zero unpowered.
// - Only hardware sets enable after high-speed reset; faults or software may disable.
// - Connect change sets on every connect status change, even if already set.
// - Connect status reads presence; status bits other than over-current active read zero while power is off.
// - Configure flag zero routes ports to companion; one routes by the owner bit, cleared to this controller on the rise.
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
module uhrpc_port #(
  parameter int unsigned SETTLE_COUNT = uhrpc_pkg::SETTLE_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [31:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        line_dp,
  input  wire logic        line_dm,
  input  wire logic        device_present,
  input  wire logic        device_high_speed,
  input  wire logic        overcurrent_in,
  input  wire logic        eof2_port_error,
  input  wire logic        transaction_busy,
  input  wire logic        high_speed_idle,
  output logic             port_power_on,
  output logic             drive_bus_reset,
  output logic             drive_resume_k,
  output logic             downstream_block,
  output logic             port_owner_companion,
  output logic             change_detect_pulse
);
  import uhrpc_pkg::*;

  // All state of the port sits in one packed struct.
  // The combinational process builds the next copy from the current one.
  // A single clocked process registers it.
  // Outside these two processes only the output flops hold state, loaded from the next copy.
  // That keeps reset values and change-flag priorities in one place.
  typedef struct packed {
    logic        configure_flag;
    logic        power_control_capable;
    logic        controller_halted;
    logic        owner;
    logic        power;
    logic        rst_active;
    logic        rst_sw;
    logic        suspend;
    logic        suspend_req;
    logic        resume;
    logic        resume_sw_held;
    logic        oc_change;
    logic        oc_active;
    logic        en_change;
    logic        enabled;
    logic        conn_change;
    logic        connect;
    logic [1:0]  line_prev;
    logic [31:0] settle_cnt;
    logic        ack;
    logic [31:0] rdata;
    logic        pcd_pulse;
  } uhrpc_state_s;

  uhrpc_state_s cur;
  uhrpc_state_s nxt;

  // Builds the software view of the port register from the state.
  // Without port power only owner, power and over-current active are visible.
  // Reserved bits always read zero.
  // The line field shows the last sampled levels.
  function automatic logic [31:0] uhrpc_port_word(input uhrpc_state_s s);
    logic [31:0] w;
    w = 32'h00000000;
    w[BIT_OWNER] = s.owner;
    w[BIT_POWER] = s.power;
    if (s.power) begin
      w[BIT_LINE_HI] = s.line_prev[1];
      w[BIT_LINE_LO] = s.line_prev[0];
      w[BIT_RESET] = s.rst_active;
      w[BIT_SUSPEND] = s.suspend;
      w[BIT_RESUME] = s.resume;
      w[BIT_OC_CHANGE] = s.oc_change;
      w[BIT_EN_CHANGE] = s.en_change;
      w[BIT_ENABLED] = s.enabled;
      w[BIT_CONN_CHANGE] = s.conn_change;
      w[BIT_CONNECT] = s.connect;
    end
    w[BIT_OC_ACTIVE] = s.oc_active;
    return w;
  endfunction

  logic        hit_port;
  logic        hit_cfg;
  logic        hit_aux;
  logic        wr_go;
  logic [1:0]  line_now;
  logic [31:0] wd;

  // The bus decode compares the full byte address.
  // Byte lanes two and three carry no writable field.
  // Masked lanes are forced to zero, so a masked write-one-to-clear bit does nothing.
  // A write is acted on only in the cycle before its answer.
  always_comb begin
    hit_port = (avs_address == PORT0_STATUS_CONTROL_ADDR);
    hit_cfg  = (avs_address == CONFIGURE_FLAG_REGISTER_ADDR);
    hit_aux  = (avs_address == PORT_AUX_CONTROL_ADDR);
    wr_go    = avs_write && !cur.ack;
    line_now = {line_dp, line_dm};
    wd       = avs_writedata;
    if (!avs_byteenable[0]) begin
      wd[7:0] = 8'h00;
    end
    if (!avs_byteenable[1]) begin
      wd[15:8] = 8'h00;
    end
  end

  always_comb begin
    nxt = cur;
    nxt.pcd_pulse = 1'b0;
    // Every access takes one wait cycle so the answer comes from a flop.
    nxt.ack = (avs_read || avs_write) && !cur.ack;
    if (avs_read && !cur.ack) begin
      if (hit_port) begin
        nxt.rdata = uhrpc_port_word(cur);
      end else if (hit_cfg) begin
        nxt.rdata = {31'h00000000, cur.configure_flag};
      end else if (hit_aux) begin
        nxt.rdata = {30'h00000000, cur.controller_halted, cur.power_control_capable};
      end else begin
        nxt.rdata = UNMAPPED_READ;
      end
    end

    // Line levels are sampled every cycle.
    // The previous sample is kept to spot a J-to-K step while suspended.
    // Over-current follows its pin without filtering.
    // Its change flag is set on both edges of the condition.
    nxt.line_prev = line_now;
    nxt.oc_active = overcurrent_in;
    if (overcurrent_in != cur.oc_active) begin
      nxt.oc_change = 1'b1;
    end
    if (overcurrent_in && cur.power && cur.power_control_capable) begin
      nxt.power = 1'b0;
    end

    // An unpowered port ignores attach and detach, so connect is tracked only with power.
    // A detach silently disables the port.
    // Only an error at the end of a frame raises the enable-change flag.
    // A disconnect does not set it.
    if (cur.power) begin
      nxt.connect = device_present;
      if (device_present != cur.connect) begin
        nxt.conn_change = 1'b1;
      end
      if (!device_present && cur.enabled) begin
        nxt.enabled = 1'b0;
      end
      if (eof2_port_error && cur.enabled) begin
        nxt.enabled = 1'b0;
        nxt.en_change = 1'b1;
      end
    end

    // Suspend takes effect only once the current transaction has finished.
    if (cur.suspend_req && !transaction_busy) begin
      nxt.suspend = cur.enabled;
      nxt.suspend_req = 1'b0;
    end
    if (cur.suspend && !cur.resume && cur.line_prev == LINE_J && line_now == LINE_K) begin
      nxt.resume = 1'b1;
      nxt.pcd_pulse = 1'b1;
    end
    if (cur.resume && !cur.resume_sw_held && high_speed_idle) begin
      nxt.resume = 1'b0;
      nxt.suspend = 1'b0;
    end

    // Reset stays reported until the settle timer or a high-speed device finishes the sequence.
    // A high-speed device ends the sequence at once and enables the port.
    // Any other device waits for the timer and leaves the port disabled.
    if (cur.rst_active && !cur.rst_sw) begin
      if (cur.settle_cnt != 32'h00000000) begin
        nxt.settle_cnt = cur.settle_cnt - 32'h00000001;
      end
      if (cur.settle_cnt <= 32'h00000001 || device_high_speed) begin
        nxt.rst_active = 1'b0;
        nxt.enabled = device_high_speed && device_present;
        nxt.settle_cnt = 32'h00000000;
      end
    end
    if (cur.controller_halted && cur.rst_active) begin
      nxt.rst_active = 1'b1;
    end

    // Software writes come last, so they override hardware updates of the same cycle.
    // The change flags are the exception: their clear keeps a set of the same cycle.
    // The configure flag and the auxiliary register are local stand-ins.
    // They model controller-wide state that the real port only observes.
    if (wr_go && hit_cfg && avs_byteenable[0]) begin
      nxt.configure_flag = avs_writedata[0];
      if (avs_writedata[0] && !cur.configure_flag) begin
        nxt.owner = 1'b0;
      end
    end
    if (wr_go && hit_aux && avs_byteenable[0]) begin
      nxt.power_control_capable = avs_writedata[BIT_AUX_PPC];
      nxt.controller_halted = avs_writedata[BIT_AUX_HALTED];
    end
    if (wr_go && hit_port) begin
      if (avs_byteenable[1]) begin
        nxt.owner = wd[BIT_OWNER];
        nxt.power = wd[BIT_POWER];
        if (wd[BIT_RESET] && !cur.rst_sw) begin
          nxt.rst_active = 1'b1;
          nxt.rst_sw = 1'b1;
          nxt.suspend = 1'b0;
          nxt.suspend_req = 1'b0;
          nxt.enabled = 1'b0;
        end else if (!wd[BIT_RESET] && cur.rst_sw) begin
          nxt.rst_sw = 1'b0;
          nxt.settle_cnt = SETTLE_COUNT;
        end
      end
      if (avs_byteenable[0]) begin
        if (wd[BIT_SUSPEND] && cur.enabled) begin
          nxt.suspend_req = 1'b1;
        end
        if (wd[BIT_RESUME] && !cur.resume) begin
          nxt.resume = 1'b1;
          nxt.resume_sw_held = 1'b1;
        end else if (!wd[BIT_RESUME] && cur.resume_sw_held) begin
          nxt.resume_sw_held = 1'b0;
          nxt.suspend = 1'b0;
        end
        if (wd[BIT_OC_CHANGE]) begin
          nxt.oc_change = (overcurrent_in != cur.oc_active);
        end
        if (wd[BIT_EN_CHANGE]) begin
          nxt.en_change = eof2_port_error && cur.enabled;
        end
        if (wd[BIT_CONN_CHANGE]) begin
          nxt.conn_change = cur.power && (device_present != cur.connect);
        end
        if (!wd[BIT_ENABLED]) begin
          nxt.enabled = 1'b0;
          nxt.suspend = 1'b0;
        end
      end
    end

    // Removing power wipes all port status, whatever caused the loss.
    // This also cancels a pending suspend and any reset in progress.
    // The owner bit survives, since routing does not depend on power.
    // Over-current active stays visible, so software can see why power dropped.
    if (!nxt.power) begin
      nxt.connect = 1'b0;
      nxt.conn_change = 1'b0;
      nxt.en_change = 1'b0;
      nxt.enabled = 1'b0;
      nxt.suspend = 1'b0;
      nxt.suspend_req = 1'b0;
      nxt.resume = 1'b0;
      nxt.resume_sw_held = 1'b0;
      nxt.rst_active = 1'b0;
      nxt.rst_sw = 1'b0;
      nxt.oc_change = 1'b0;
    end
    if (!nxt.enabled) begin
      nxt.suspend = 1'b0;
    end
    if (!nxt.configure_flag) begin
      nxt.owner = 1'b1;
    end
  end

  // The reset branch loads constants only.
  // Owner and power take their values from the register's reset word.
  // The port therefore starts unpowered and owned by the companion controller.
  // Software must power the port before any attach is reported.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cur <= '0;
      cur.owner <= PORT0_RESET_VALUE[BIT_OWNER];
      cur.power <= PORT0_RESET_VALUE[BIT_POWER];
    end else begin
      cur <= nxt;
    end
  end

  // Outputs come straight from their own flops.
  // They are loaded from the next state, so they match the register view at every edge.
  // Waitrequest is high in idle and low for exactly one cycle per access.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      avs_readdata         <= 32'h00000000;
      avs_waitrequest      <= 1'b1;
      port_power_on        <= 1'b0;
      drive_bus_reset      <= 1'b0;
      drive_resume_k       <= 1'b0;
      downstream_block     <= 1'b1;
      port_owner_companion <= 1'b1;
      change_detect_pulse  <= 1'b0;
    end else begin
      avs_readdata         <= nxt.rdata;
      avs_waitrequest      <= !nxt.ack;
      port_power_on        <= nxt.power;
      drive_bus_reset      <= nxt.rst_active;
      drive_resume_k       <= nxt.resume && nxt.resume_sw_held;
      downstream_block     <= !nxt.enabled || nxt.suspend || nxt.suspend_req;
      port_owner_companion <= nxt.owner;
      change_detect_pulse  <= nxt.pcd_pulse;
    end
  end
endmodule
`default_nettype wire

/* include/uhrpc_pkg.sv */
// Package with register layout, reset values and timing constants for the root port control.
package uhrpc_pkg;
  localparam int unsigned CLK_HZ = 125000000;
  localparam logic [31:0] PORT0_STATUS_CONTROL_ADDR = 32'hB0005064;
  localparam logic [31:0] CONFIGURE_FLAG_REGISTER_ADDR = 32'hB0005060;
  localparam logic [31:0] PORT_AUX_CONTROL_ADDR = 32'hB0005070;
  localparam logic [31:0] PORT0_RESET_VALUE = 32'h00002000;
  localparam int unsigned BIT_OWNER = 13;
  localparam int unsigned BIT_POWER = 12;
  localparam int unsigned BIT_LINE_HI = 11;
  localparam int unsigned BIT_LINE_LO = 10;
  localparam int unsigned BIT_RESET = 8;
  localparam int unsigned BIT_SUSPEND = 7;
  localparam int unsigned BIT_RESUME = 6;
  localparam int unsigned BIT_OC_CHANGE = 5;
  localparam int unsigned BIT_OC_ACTIVE = 4;
  localparam int unsigned BIT_EN_CHANGE = 3;
  localparam int unsigned BIT_ENABLED = 2;
  localparam int unsigned BIT_CONN_CHANGE = 1;
  localparam int unsigned BIT_CONNECT = 0;
  localparam int unsigned BIT_AUX_PPC = 0;
  localparam int unsigned BIT_AUX_HALTED = 1;
  localparam int unsigned SETTLE_TIME_US = 2000;
  localparam int unsigned SETTLE_CYCLES = SETTLE_TIME_US * (CLK_HZ / 1000000);
  localparam logic [1:0] LINE_J = 2'h2;
  localparam logic [1:0] LINE_K = 2'h1;
  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
endpackage

/* verif/uhrpc_port_monitor.sv */
// Checker of the register slave and port outputs of the root port control.
`timescale 1ns/1ns
`default_nettype none
module uhrpc_port_monitor
  import uhrpc_pkg::*;
#(
  parameter int unsigned SETTLE_COUNT = 20
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [31:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        port_power_on,
  input wire logic        drive_bus_reset,
  input wire logic        drive_resume_k,
  input wire logic        port_owner_companion,
  input wire logic        change_detect_pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic req;
  logic done;
  assign req = avs_read || avs_write;
  assign done = !avs_waitrequest;
  wait_once_a: assert property (done |=> avs_waitrequest)
    else $error("waitrequest low for two cycles");
  answer_next_a: assert property (req && avs_waitrequest |=> done)
    else $error("access not answered in one cycle");
  idle_wait_a: assert property (!$past(req) |-> avs_waitrequest)
    else $error("waitrequest low without a request");
  pulse_once_a: assert property (change_detect_pulse |=> !change_detect_pulse)
    else $error("change pulse longer than one cycle");
  unpowered_quiet_a: assert property (!port_power_on [*2] |-> !drive_bus_reset && !drive_resume_k)
    else $error("port signalling while unpowered");
  owner_forced_a: assert property (avs_write && done && avs_address == CONFIGURE_FLAG_REGISTER_ADDR
    && avs_byteenable[0] && !avs_writedata[0] |-> ##[1:2] port_owner_companion)
    else $error("owner not forced while flag is zero");
  reset_start_a: assert property (avs_write && done && avs_address == PORT0_STATUS_CONTROL_ADDR
    && avs_byteenable[1] && avs_writedata[BIT_RESET] && avs_writedata[BIT_POWER]
    && port_power_on |-> ##[1:2] drive_bus_reset)
    else $error("bus reset not started");
  unmapped_zero_a: assert property (avs_read && done && avs_address != PORT0_STATUS_CONTROL_ADDR
    && avs_address != CONFIGURE_FLAG_REGISTER_ADDR && avs_address != PORT_AUX_CONTROL_ADDR
    |-> avs_readdata == UNMAPPED_READ)
    else $error("unmapped read not zero");
  reserved_zero_a: assert property (avs_read && done && avs_address == PORT0_STATUS_CONTROL_ADDR
    |-> avs_readdata[31:14] == 18'h0 && !avs_readdata[9])
    else $error("reserved port bits not zero");
  cover property (change_detect_pulse);
  cover property (drive_bus_reset);
  cover property (drive_resume_k);
endmodule
bind uhrpc_port uhrpc_port_monitor #(.SETTLE_COUNT(SETTLE_COUNT)) u_mon (.clk(clk), .reset(reset),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .port_power_on(port_power_on),
  .drive_bus_reset(drive_bus_reset), .drive_resume_k(drive_resume_k),
  .port_owner_companion(port_owner_companion), .change_detect_pulse(change_detect_pulse));
`default_nettype wire

/* verif/uhrpc_dev_model.sv */
// Behavioural USB device attached to the root port.
`timescale 1ns/1ns
`default_nettype none
module uhrpc_dev_model (
  input  wire logic       clk,
  input  wire logic       attach,
  input  wire logic       hs_capable,
  input  wire logic [1:0] line_sel,
  input  wire logic       busy,
  input  wire logic       idle_req,
  input  wire logic       drive_resume_k,
  output logic            line_dp,
  output logic            line_dm,
  output logic            device_present,
  output logic            device_high_speed,
  output logic            transaction_busy,
  output var logic        high_speed_idle = 1'b0
);
  // A detached device leaves both lines to the host pull-downs.
  assign line_dp = attach && line_sel[1];
  assign line_dm = attach && line_sel[0];
  assign device_present = attach;
  assign device_high_speed = attach && hs_capable;
  assign transaction_busy = attach && busy;
  // Idle is only reached once the host stops driving resume K.
  always_ff @(posedge clk) begin
    high_speed_idle <= idle_req && !drive_resume_k;
  end
endmodule
`default_nettype wire

/* verif/usb_host_root_port_control_tb_top.sv */
// Self-checking testbench of the root port control.
`timescale 1ns/1ns
`default_nettype none
module usb_host_root_port_control_tb_top;
  import uhrpc_pkg::*;
  localparam logic [31:0] P = PORT0_STATUS_CONTROL_ADDR;
  localparam logic [31:0] C = CONFIGURE_FLAG_REGISTER_ADDR;
  localparam logic [31:0] M = 32'h000031FF;
  logic        clk = 1'b0, reset = 1'b1, rd = 1'b0, wr_en = 1'b0, busy = 1'b0, oc = 1'b0;
  logic        attach = 1'b0, hs = 1'b0, idle_req = 1'b0, eof2 = 1'b0;
  logic [1:0]  line_sel = 2'h0;
  logic [31:0] addr = 32'h0, wdata = 32'h0, rdata;
  logic        waitreq, dp, dm, pres, hsd, tbusy, hsi, pwr, bres, rk, blk, own, cdp;
  int          error_cnt = 0, samples_checked = 0, cyc = 0, pulses = 0;
  always #4 clk = ~clk;
  uhrpc_port #(.SETTLE_COUNT(20)) u_dut (.clk(clk), .reset(reset), .avs_address(addr),
    .avs_read(rd), .avs_write(wr_en), .avs_writedata(wdata), .avs_byteenable(4'hF),
    .avs_readdata(rdata), .avs_waitrequest(waitreq), .line_dp(dp), .line_dm(dm),
    .device_present(pres), .device_high_speed(hsd), .overcurrent_in(oc),
    .eof2_port_error(eof2), .transaction_busy(tbusy), .high_speed_idle(hsi),
    .port_power_on(pwr), .drive_bus_reset(bres), .drive_resume_k(rk),
    .downstream_block(blk), .port_owner_companion(own), .change_detect_pulse(cdp));
  uhrpc_dev_model u_dev (.clk(clk), .attach(attach), .hs_capable(hs), .line_sel(line_sel),
    .busy(busy), .idle_req(idle_req), .drive_resume_k(rk), .line_dp(dp), .line_dm(dm),
    .device_present(pres), .device_high_speed(hsd), .transaction_busy(tbusy),
    .high_speed_idle(hsi));
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Request rises after an edge and is held until waitrequest is sampled low.
  task automatic acc(input logic w, input logic [31:0] a, d, output logic [31:0] q);
    addr <= a;
    wdata <= d;
    wr_en <= w;
    rd <= !w;
    do @(posedge clk); while (waitreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr_en <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [31:0] a, m, e);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cdp === 1'b1) pulses++;
    if (cyc == 3000) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rdc(P, 32'hFFFFFFFF, 32'h00002000);
    wr(C, 32'h1);
    wr(P, 32'h1000);
    rdc(P, 32'hFFFFFFFF, 32'h00001000);
    attach <= 1'b1;
    hs <= 1'b1;
    line_sel <= 2'h2;
    repeat (4) @(posedge clk);
    rdc(P, 32'hFFFFFFFF, 32'h00001803);
    wr(P, 32'h1002);
    rdc(P, 32'hFFFFFFFF, 32'h00001801);
    wr(P, 32'h1100);
    rdc(P, M, 32'h00001101);
    chk(32'(bres), 32'h1);
    wr(P, 32'h1000);
    repeat (3) @(posedge clk);
    rdc(P, M, 32'h00001005);
    busy <= 1'b1;
    wr(P, 32'h1084);
    rdc(P, M, 32'h00001005);
    busy <= 1'b0;
    repeat (2) @(posedge clk);
    rdc(P, M, 32'h00001085);
    chk(32'(blk), 32'h1);
    wr(P, 32'h1004);
    rdc(P, M, 32'h00001085);
    line_sel <= 2'h1;
    repeat (4) @(posedge clk);
    rdc(P, M, 32'h000010C5);
    chk(32'(pulses), 32'h1);
    line_sel <= 2'h2;
    idle_req <= 1'b1;
    repeat (4) @(posedge clk);
    rdc(P, M, 32'h00001005);
    idle_req <= 1'b0;
    oc <= 1'b1;
    repeat (3) @(posedge clk);
    rdc(P, M, 32'h00001035);
    oc <= 1'b0;
    repeat (3) @(posedge clk);
    wr(P, 32'h1024);
    rdc(P, M, 32'h00001005);
    eof2 <= 1'b1;
    @(posedge clk);
    eof2 <= 1'b0;
    repeat (2) @(posedge clk);
    rdc(P, M, 32'h00001009);
    wr(P, 32'h1008);
    rdc(P, M, 32'h00001001);
    rdc(32'hB0005080, 32'hFFFFFFFF, 32'h0);
    wr(P, 32'h0);
    rdc(P, M, 32'h0);
    wr(C, 32'h0);
    rdc(P, M, 32'h00002000);
    wr(PORT_AUX_CONTROL_ADDR, 32'h1);
    wr(P, 32'h1000);
    oc <= 1'b1;
    repeat (4) @(posedge clk);
    chk(32'(pwr), 32'h0);
    oc <= 1'b0;
    wr(C, 32'h1);
    wr(PORT_AUX_CONTROL_ADDR, 32'h0);
    wr(P, 32'h1000);
    line_sel <= 2'h1;
    repeat (4) @(posedge clk);
    rdc(P, 32'hFFFFFFFF, 32'h00001403);
    wr(P, 32'h3000);
    rdc(P, M, 32'h00003003);
    chk(32'(own), 32'h1);
    hs <= 1'b0;
    wr(P, 32'h1100);
    wr(P, 32'h1000);
    rdc(P, M, 32'h00001103);
    repeat (20) @(posedge clk);
    rdc(P, M, 32'h00001003);
    chk(32'(bres), 32'h0);
    wr(PORT_AUX_CONTROL_ADDR, 32'h2);
    wr(P, 32'h1100);
    wr(P, 32'h1000);
    repeat (25) @(posedge clk);
    rdc(P, M, 32'h00001103);
    wr(PORT_AUX_CONTROL_ADDR, 32'h0);
    repeat (2) @(posedge clk);
    rdc(P, M, 32'h00001003);
    wrap_up();
  end
endmodule
`default_nettype wire
